// ===== bench/late_write_pipelined_sram_core_bench.sv
// Bench joining both ends; reads checked against a word model
module late_write_pipelined_sram_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef logic [lw_sram_pkg::DATA_W-1:0] word_t;
   typedef logic [lw_sram_pkg::ADDR_W-1:0] addr_t;
   logic                          core_clk_in, rst_n_in, req_valid, req_write;
   logic                          sleep, zq_high, rdata_valid, zq_ready;
   addr_t                         req_addr;
   logic [lw_sram_pkg::LANES-1:0] req_lane_n;
   word_t                         req_wdata, rdata;
   logic [lw_sram_pkg::ZQ_W-1:0]  zq_code, zq_start;
   word_t                         model [addr_t];
   int                            n_mismatch = 0, tests_run = 0, cyc = 0;
   lw_sram_if bus ();
   lw_sram_mem lw_sram_mem_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .bus(bus.mem), .zq_too_high_in(zq_high), .zq_code_out(zq_code),
      .zq_ready_out(zq_ready));
   lw_sram_ctl lw_sram_ctl_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .bus(bus.ctl), .req_valid_in(req_valid), .req_write_in(req_write),
      .req_addr_in(req_addr), .req_lane_n_in(req_lane_n),
      .req_wdata_in(req_wdata), .sleep_in(sleep),
      .rdata_valid_out(rdata_valid), .rdata_out(rdata));
   lw_sram_sva lw_sram_sva_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .select_n(bus.select_n), .write_enable_n(bus.write_enable_n),
      .byte_lane_write_n(bus.byte_lane_write_n),
      .out_enable_n(bus.out_enable_n), .sleep_request(bus.sleep_request),
      .ctl_dq_oe(bus.ctl_dq_oe), .mem_dq_oe(bus.mem_dq_oe));
   // 40 MHz core clock and a cycle count since reset release
   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) if (rst_n_in) cyc++;
   task automatic chk(input word_t got, input word_t exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One request cycle; valid stays up so requests can run back to back
   task automatic issue(input logic w, input addr_t a,
                        input logic [3:0] ln, input word_t d);
      {req_valid, req_write, req_addr} = {1'b1, w, a};
      {req_lane_n, req_wdata} = {ln, d};
      for (int i = 0; i < 4; i++)
         if (w && !ln[i]) model[a][9*i+:9] = d[9*i+:9];
      @(negedge core_clk_in);
   endtask
   task automatic rd_chk(input addr_t a);
      int k;
      issue(1'b0, a, 4'hF, '0);
      req_valid = 1'b0;
      for (k = 0; k < 8 && rdata_valid !== 1'b1; k++) @(posedge core_clk_in) #1;
      // Command one edge after request, data on the second edge, then
      // the controller's own register: three edges after the command
      chk(word_t'(k), 36'h3);
      chk(rdata, model[a]);
      @(negedge core_clk_in);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard: startup count plus calibration window and traffic
   initial begin
      repeat (60000) @(posedge core_clk_in);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      {req_valid, req_write, sleep, zq_high, rst_n_in} = '0;
      {req_addr, req_lane_n, req_wdata} = '0;
      repeat (8) @(posedge core_clk_in);
      @(negedge core_clk_in);
      rst_n_in = 1'b1;
      @(negedge core_clk_in);
      issue(1'b1, 19'h00000, 4'h0, 36'h123456789);
      rd_chk(19'h00000);
      issue(1'b1, 19'h7FFFF, 4'h0, 36'hFEDCBA987);
      rd_chk(19'h7FFFF);
      issue(1'b1, 19'h00005, 4'h0, 36'h000000000);
      // Single lanes; the read right behind changes lanes on the data edge
      for (int i = 0; i < 4; i++) begin
         issue(1'b1, 19'h00005, ~(4'h1 << i), 36'h9ABCDEF01 + 36'(i));
         rd_chk(19'h00005);
      end
      issue(1'b1, 19'h00005, 4'hF, 36'hFFFFFFFFF);
      rd_chk(19'h00005);
      // Sleep lands while read data is due; the pins must stay released
      issue(1'b0, 19'h00000, 4'hF, '0);
      req_valid = 1'b0;
      @(negedge core_clk_in);
      sleep = 1'b1;
      repeat (2) @(posedge core_clk_in);
      #1;
      chk(rdata, '0);
      repeat (6) @(negedge core_clk_in);
      sleep = 1'b0;
      repeat (2) @(negedge core_clk_in);
      rd_chk(19'h00000);
      while (zq_ready !== 1'b1 && cyc < 40000) @(negedge core_clk_in);
      chk(word_t'(zq_ready === 1'b1 && cyc >= 32768), 36'h1);
      zq_high = 1'b1;
      zq_start = zq_code;
      repeat (2048) @(negedge core_clk_in);
      chk(word_t'((zq_code - zq_start) inside {6'h1, 6'h2}), 36'h1);
      end_of_test();
   end
endmodule

// ===== bench/lw_sram_sva.sv
// Concurrent checks on the link between controller and memory ends
module lw_sram_sva (
   input wire logic                          core_clk_in,
   input wire logic                          rst_n_in,
   input wire logic                          select_n,
   input wire logic                          write_enable_n,
   input wire logic [lw_sram_pkg::LANES-1:0] byte_lane_write_n,
   input wire logic                          out_enable_n,
   input wire logic                          sleep_request,
   input wire logic                          ctl_dq_oe,
   input wire logic                          mem_dq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Commands as the memory samples them; sleep blocks both kinds
   wire logic rd = !select_n && write_enable_n && !sleep_request;
   wire logic wr = !select_n && !write_enable_n && !sleep_request;
   wire logic abort = wr && (&byte_lane_write_n);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // ------------------------------
   // Data bus ownership
   // ------------------------------
   a_read_drive: assert property (
      rd ##1 !sleep_request |=> mem_dq_oe == (!out_enable_n && !sleep_request))
      else $error("read data not driven on second edge");
   a_oe_gate: assert property (out_enable_n |-> !mem_dq_oe)
      else $error("memory drives with output enable off");
   a_sleep_off: assert property (sleep_request |-> !mem_dq_oe)
      else $error("memory drives while asleep");
   a_desel_release: assert property (select_n |=> ##1 !mem_dq_oe)
      else $error("outputs not released after deselect");
   a_write_release: assert property (wr |=> ##1 !mem_dq_oe)
      else $error("outputs not released after write");
   // Late data follows one edge later; an abort leaves the bus idle
   a_late_data: assert property (wr && !abort |=> ctl_dq_oe)
      else $error("write data not driven one edge late");
   a_abort_quiet: assert property (abort |=> !ctl_dq_oe)
      else $error("aborted write drove the bus");
   a_read_no_ctl: assert property (rd |=> !ctl_dq_oe)
      else $error("controller drove during read");
   a_no_clash: assert property (!(ctl_dq_oe && mem_dq_oe))
      else $error("both ends drive the data bus");
endmodule

// ===== logic/lw_sram_ctl.sv
// Controller end: issues commands and drives late write data
module lw_sram_ctl (
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_n_in,
   lw_sram_if.ctl                    bus,
   input  wire logic                 req_valid_in,
   input  wire logic                 req_write_in,
   input  wire logic [lw_sram_pkg::ADDR_W-1:0] req_addr_in,
   input  wire logic [lw_sram_pkg::LANES-1:0]  req_lane_n_in,
   input  wire logic [lw_sram_pkg::DATA_W-1:0] req_wdata_in,
   input  wire logic                 sleep_in,
   output logic                      rdata_valid_out,
   output logic [lw_sram_pkg::DATA_W-1:0] rdata_out
);
   // -------------------------------------------------------------
   // Command and late data registers
   // -------------------------------------------------------------
   logic [lw_sram_pkg::DATA_W-1:0] wdata_hold;
   logic [1:0]                     rd_pipe;
   logic                           wr_stage;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus.select_n          <= 1'b1;
         bus.write_enable_n    <= 1'b1;
         bus.byte_lane_write_n <= 4'hF;
         bus.addr              <= '0;
         bus.sleep_request     <= 1'b0;
         bus.out_enable_n      <= 1'b1;
         wdata_hold            <= '0;
         wr_stage              <= 1'b0;
         rd_pipe               <= 2'h0;
         bus.ctl_dq            <= '0;
         bus.ctl_dq_oe         <= 1'b0;
         rdata_valid_out       <= 1'b0;
         rdata_out             <= '0;
      end else begin
         bus.sleep_request     <= sleep_in;
         bus.out_enable_n      <= 1'b0;
         bus.select_n          <= !(req_valid_in && !sleep_in);
         bus.write_enable_n    <= !req_write_in;
         bus.byte_lane_write_n <= req_lane_n_in;
         bus.addr              <= req_addr_in;
         wdata_hold            <= req_wdata_in;
         // An aborted write carries no data, so the bus stays released
         wr_stage <= req_valid_in && !sleep_in && req_write_in
                     && !(&req_lane_n_in);
         // Data goes out one edge behind its command
         bus.ctl_dq    <= wdata_hold;
         bus.ctl_dq_oe <= wr_stage;
         rd_pipe <= {rd_pipe[0], !bus.select_n && bus.write_enable_n
                     && !bus.sleep_request};
         rdata_valid_out <= rd_pipe[1];
         if (rd_pipe[1])
            rdata_out <= bus.dq_wire;
      end
   end
endmodule

// ===== logic/lw_sram_if.sv
// Interface joining the controller end and the memory end
interface lw_sram_if;
   logic                                select_n;
   logic                                write_enable_n;
   logic [lw_sram_pkg::LANES-1:0]       byte_lane_write_n;
   logic [lw_sram_pkg::ADDR_W-1:0]      addr;
   logic                                out_enable_n;
   logic                                sleep_request;
   logic [lw_sram_pkg::DATA_W-1:0]      ctl_dq;
   logic                                ctl_dq_oe;
   logic [lw_sram_pkg::DATA_W-1:0]      mem_dq;
   logic                                mem_dq_oe;
   logic [lw_sram_pkg::DATA_W-1:0]      dq_wire;

   // Resolved bus level; an idle wire reads as zero here
   assign dq_wire = ctl_dq_oe ? ctl_dq : (mem_dq_oe ? mem_dq : '0);

   modport mem (
      input  select_n, write_enable_n, byte_lane_write_n, addr,
      input  out_enable_n, sleep_request, dq_wire,
      output mem_dq, mem_dq_oe
   );
   modport ctl (
      output select_n, write_enable_n, byte_lane_write_n, addr,
      output out_enable_n, sleep_request, ctl_dq, ctl_dq_oe,
      input  dq_wire
   );
endinterface

// ===== logic/lw_sram_mem.sv
// Memory end: late write array with pipelined read and impedance loop
module lw_sram_mem (
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_n_in,
   lw_sram_if.mem                    bus,
   input  wire logic                 zq_too_high_in,
   output logic [lw_sram_pkg::ZQ_W-1:0] zq_code_out,
   output logic                      zq_ready_out
);
   // -------------------------------------------------------------
   // Command decode
   // -------------------------------------------------------------
   logic [lw_sram_pkg::DATA_W-1:0] mem [lw_sram_pkg::DEPTH];
   wire  awake   = !bus.sleep_request;
   wire  rd_cmd  = awake && !bus.select_n && bus.write_enable_n;
   wire  wr_cmd  = awake && !bus.select_n && !bus.write_enable_n;
   wire  wr_live = wr_cmd && (bus.byte_lane_write_n != 4'hF);

   // Pending late write, captured with its lanes at command edge
   logic                              wp_valid;
   logic [lw_sram_pkg::ADDR_W-1:0]    wp_addr;
   logic [lw_sram_pkg::LANES-1:0]     wp_lane_n;
   logic                              rd_valid;
   logic [lw_sram_pkg::ADDR_W-1:0]    rd_addr;

   function automatic logic [lw_sram_pkg::DATA_W-1:0] merge(
      input logic [lw_sram_pkg::DATA_W-1:0] old_w,
      input logic [lw_sram_pkg::DATA_W-1:0] new_w,
      input logic [lw_sram_pkg::LANES-1:0]  lane_n);
      logic [lw_sram_pkg::DATA_W-1:0] r;
      r = old_w;
      for (int i = 0; i < lw_sram_pkg::LANES; i++) begin
         if (!lane_n[i])
            r[i*lw_sram_pkg::LANE_W +: lw_sram_pkg::LANE_W] =
               new_w[i*lw_sram_pkg::LANE_W +: lw_sram_pkg::LANE_W];
      end
      return r;
   endfunction

   // Late data on the wire this edge commits the pending write
   wire [lw_sram_pkg::DATA_W-1:0] wr_merged =
      merge(mem[wp_addr], bus.dq_wire, wp_lane_n);
   // A write commits on its data edge, never later than the fetch of a
   // read issued after it, so reads see the newer bytes with no bypass
   wire [lw_sram_pkg::DATA_W-1:0] rd_word = mem[rd_addr];

   // -------------------------------------------------------------
   // Command pipeline; valid flags drop during sleep so contents stay put
   // -------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wp_valid  <= 1'b0;
         wp_addr   <= '0;
         wp_lane_n <= 4'hF;
         rd_valid  <= 1'b0;
         rd_addr   <= '0;
      end else begin
         wp_valid  <= wr_live;
         wp_addr   <= bus.addr;
         wp_lane_n <= bus.byte_lane_write_n;
         rd_valid  <= rd_cmd;
         rd_addr   <= bus.addr;
      end
   end

   // Array write; no reset so contents survive sleep and reset
   always_ff @(posedge core_clk_in) begin
      if (wp_valid)
         mem[wp_addr] <= wr_merged;
   end

   // -------------------------------------------------------------
   // Output register and driver enable
   // -------------------------------------------------------------
   logic                           q_valid;
   logic [lw_sram_pkg::DATA_W-1:0] q_data;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q_valid <= 1'b0;
         q_data  <= '0;
      end else begin
         q_valid <= rd_valid && awake;
         if (rd_valid)
            q_data <= rd_word;
      end
   end
   assign bus.mem_dq    = q_data;
   // Output enable is asynchronous; sleep releases at once
   assign bus.mem_dq_oe = q_valid && !bus.out_enable_n
                          && awake;

   // -------------------------------------------------------------
   // Impedance calibration loop
   // -------------------------------------------------------------
   logic [lw_sram_pkg::CNT_W-1:0] period_cnt;
   logic [lw_sram_pkg::CNT_W:0]   start_cnt;
   wire  eval = period_cnt ==
                lw_sram_pkg::CNT_W'(lw_sram_pkg::ZQ_PERIOD_CYC-1);
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         period_cnt   <= '0;
         start_cnt    <= '0;
         zq_code_out  <= lw_sram_pkg::ZQ_RESET_CODE;
         zq_ready_out <= 1'b0;
      end else begin
         period_cnt <= eval ? '0 : period_cnt + 1'b1;
         if (!zq_ready_out)
            start_cnt <= start_cnt + 1'b1;
         zq_ready_out <= start_cnt >=
            (lw_sram_pkg::CNT_W+1)'(lw_sram_pkg::ZQ_STARTUP_CYC-1);
         // Single step only, so noise can never swing the driver far
         if (eval && zq_too_high_in && zq_code_out != '1)
            zq_code_out <= zq_code_out + 1'b1;
         else if (eval && !zq_too_high_in && zq_code_out != '0)
            zq_code_out <= zq_code_out - 1'b1;
      end
   end
endmodule

// ===== logic/lw_sram_pkg.sv
// Package of constants shared by both ends of the late write memory link
package lw_sram_pkg;
   // -------------------------------------------------------------
   // Geometry
   // -------------------------------------------------------------
   localparam int ADDR_W  = 19;
   localparam int LANES   = 4;
   localparam int LANE_W  = 9;
   localparam int DATA_W  = LANES * LANE_W;
   localparam int DEPTH   = 524288;
   // -------------------------------------------------------------
   // Impedance calibration
   // -------------------------------------------------------------
   localparam int ZQ_W             = 6;
   localparam int ZQ_PERIOD_CYC    = 1024;
   localparam int ZQ_STARTUP_CYC   = 32768;
   localparam logic [ZQ_W-1:0] ZQ_RESET_CODE = 6'h20;
   localparam int CNT_W            = 16;
endpackage
